// file: core/ecsu_params.svh
// Constants of the encoder command and status unit
`ifndef ECSU_PARAMS_SVH
`define ECSU_PARAMS_SVH
`define ECSU_ST_OK       8'h00
`define ECSU_ST_ALIGN    8'h01
`define ECSU_ST_OFFSET   8'h02
`define ECSU_ST_TABLE    8'h03
`define ECSU_ST_LIMITS   8'h04
`define ECSU_ST_TWI      8'h05
`define ECSU_ST_ICSUM    8'h06
`define ECSU_ST_WDOG     8'h07
`define ECSU_ST_PARITY   8'h09
`define ECSU_ST_FCSUM    8'h0A
`define ECSU_ST_UNKNOWN  8'h0B
`define ECSU_ST_LENGTH   8'h0C
`define ECSU_ST_ARG      8'h0D
`define ECSU_ST_WPROT    8'h0E
`define ECSU_ST_ACCESS   8'h0F
`define ECSU_ST_FIXED    8'h10
`define ECSU_ST_WADDR    8'h11
`define ECSU_ST_NOFIELD  8'h12
`define ECSU_ST_ANALOG   8'h1C
`define ECSU_ST_CURRENT  8'h1D
`define ECSU_ST_TEMP     8'h1E
`define ECSU_ST_SPEED    8'h1F
`define ECSU_CMD_POS_RD  8'h42
`define ECSU_CMD_POS_SET 8'h43
`define ECSU_CMD_ANA_RD  8'h44
`define ECSU_CMD_CNT_RD  8'h46
`define ECSU_CMD_CNT_INC 8'h47
`define ECSU_CMD_CNT_CLR 8'h49
`define ECSU_CMD_DAT_RD  8'h4A
`define ECSU_CMD_DAT_WR  8'h4B
`define ECSU_CMD_FLD_ST  8'h4C
`define ECSU_CMD_FLD_MK  8'h4D
`define ECSU_CMD_FREE    8'h4E
`define ECSU_CMD_STAT_RD 8'h50
`define ECSU_CH_TEMP     8'h48
`define ECSU_CH_ALT      8'hF0
`define ECSU_DEF_ADDR    8'h40
`define ECSU_DEF_MODE    8'hE4
`define ECSU_DEF_CODE    8'h55
`define ECSU_DEF_COUNT   16'h0000
`define ECSU_NFIELD      4
`define ECSU_FLD_MAX     7'h10
`define ECSU_MEM_BYTES   8'h40
`define ECSU_NFAULT      11
`define ECSU_F_WDOG      6
`define ECSU_F_SPEED     7
`endif

// file: core/ecsu_pkg.sv
// Types of the encoder command and status unit
package ecsu_pkg;
    typedef logic [7:0]  ecsu_byte_t;
    typedef logic [6:0]  ecsu_size_t;
    typedef logic [10:0] ecsu_fault_t;
endpackage

// file: core/ecsu_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
module ecsu_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    input  wire logic         ce_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    // Value taken only once stages two and three agree
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            s1  <= '0;
            s2  <= '0;
            s3  <= '0;
            q_o <= '0;
        end
        else if (ce_i)
        begin
            s1 <= d_i;
            s2 <= s1;
            s3 <= s2;
            for (int i = 0; i < W; i++)
            begin
                if (s2[i] == s3[i])
                begin
                    q_o[i] <= s3[i];
                end
            end
        end
    end
endmodule

// file: core/ecsu_top.sv
// Command decoder, status reporting and data fields of the encoder
// Notes on behaviour
// - No fault detected: status code 00h.
// - Initialisation faults: 01h bad alignment, 02h bad angular offset.
// - 03h partition table corrupted, 04h analog limits missing.
// - 05h internal two-wire bus failed, 06h internal checksum error.
// - 07h after a watchdog-forced restart.
// - Frame errors: 09h parity, 0Ah checksum mismatch.
// - 0Bh unknown command, 0Ch wrong data byte count.
// - Forbidden argument is rejected with 0Dh.
// - Write to protected field is refused with 0Eh.
// - 0Fh wrong access code, 10h resize of fixed-size field.
// - 11h word address beyond field, 12h field does not exist.
// - Shaft too fast: 1Fh instead of a position.
// - 1Ch analog monitor, 1Dh current or parameter_ram, 1Eh temperature.
// - Decode 4Ch field status, 4Dh create field, 4Eh free memory.
// - Vital commands need a key byte matching code 0, 55h at delivery.
`timescale 1ns/1ns
`include "ecsu_params.svh"
module ecsu_top (
    input  wire logic                    CLK_I,
    input  wire logic                    RST_N_I,
    input  wire logic                    CE_I,
    input  wire logic                    CMD_STROBE_I,
    input  wire ecsu_pkg::ecsu_byte_t    CMD_CODE_I,
    input  wire logic [2:0]              CMD_LEN_I,
    input  wire ecsu_pkg::ecsu_byte_t    CMD_B1_I,
    input  wire ecsu_pkg::ecsu_byte_t    CMD_B2_I,
    input  wire ecsu_pkg::ecsu_byte_t    CMD_B3_I,
    input  wire ecsu_pkg::ecsu_byte_t    CMD_B4_I,
    input  wire logic                    PARITY_ERR_I,
    input  wire logic                    CSUM_ERR_I,
    input  wire logic [14:0]             POSITION_I,
    input  wire ecsu_pkg::ecsu_byte_t    TEMP_I,
    input  wire ecsu_pkg::ecsu_fault_t   FAULT_I,
    output logic                         RSP_VALID_O,
    output ecsu_pkg::ecsu_byte_t         RSP_STATUS_O,
    output logic [15:0]                  RSP_DATA_O,
    output ecsu_pkg::ecsu_byte_t         ERR_CODE_O,
    output ecsu_pkg::ecsu_byte_t         ADDR_O,
    output ecsu_pkg::ecsu_byte_t         LINE_MODE_O
);
    logic                  rst_a;
    logic                  rst_n;
    ecsu_pkg::ecsu_fault_t flt;
    ecsu_pkg::ecsu_fault_t flt_q;
    ecsu_pkg::ecsu_byte_t  acc_code [`ECSU_NFIELD];
    logic                  fld_on   [`ECSU_NFIELD];
    logic                  fld_wp   [`ECSU_NFIELD];
    logic                  fld_fix  [`ECSU_NFIELD];
    ecsu_pkg::ecsu_size_t  fld_size [`ECSU_NFIELD];
    ecsu_pkg::ecsu_byte_t  mem      [`ECSU_MEM_BYTES];
    ecsu_pkg::ecsu_byte_t  used;
    logic [14:0]           pos_ofs;
    logic [15:0]           counter;

    // Reset released through two flops
    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            rst_a <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_a <= 1'b1;
            rst_n <= rst_a;
        end
    end

    ecsu_sync #(.W(`ECSU_NFAULT)) u_fault_sync (
        .clk_i   (CLK_I),
        .rst_n_i (rst_n),
        .ce_i    (CE_I),
        .d_i     (FAULT_I),
        .q_o     (flt)
    );

    // Expected data byte count per command; bit 3 flags a known code
    function automatic logic [3:0] exp_len(input ecsu_pkg::ecsu_byte_t c);
        case (c)
            `ECSU_CMD_POS_RD, `ECSU_CMD_CNT_RD, `ECSU_CMD_CNT_INC,
            `ECSU_CMD_FREE, `ECSU_CMD_STAT_RD: exp_len = 4'h8;
            `ECSU_CMD_ANA_RD, `ECSU_CMD_CNT_CLR,
            `ECSU_CMD_FLD_ST:                  exp_len = 4'h9;
            `ECSU_CMD_DAT_RD:                  exp_len = 4'hA;
            `ECSU_CMD_POS_SET, `ECSU_CMD_FLD_MK: exp_len = 4'hB;
            `ECSU_CMD_DAT_WR:                  exp_len = 4'hC;
            default:                           exp_len = 4'h0;
        endcase
    endfunction

    // Fault code of the lowest newly raised fault line
    function automatic ecsu_pkg::ecsu_byte_t fault_code(input ecsu_pkg::ecsu_fault_t r);
        fault_code = `ECSU_ST_OK;
        for (int i = `ECSU_NFAULT - 1; i >= 0; i--)
        begin
            if (r[i])
            begin
                case (i)
                    0:       fault_code = `ECSU_ST_ALIGN;
                    1:       fault_code = `ECSU_ST_OFFSET;
                    2:       fault_code = `ECSU_ST_TABLE;
                    3:       fault_code = `ECSU_ST_LIMITS;
                    4:       fault_code = `ECSU_ST_TWI;
                    5:       fault_code = `ECSU_ST_ICSUM;
                    6:       fault_code = `ECSU_ST_WDOG;
                    7:       fault_code = `ECSU_ST_SPEED;
                    8:       fault_code = `ECSU_ST_ANALOG;
                    9:       fault_code = `ECSU_ST_CURRENT;
                    default: fault_code = `ECSU_ST_TEMP;
                endcase
            end
        end
    endfunction

    wire                       take      = CMD_STROBE_I & CE_I;
    wire [3:0]                 el        = exp_len(CMD_CODE_I);
    wire [1:0]                 fld       = CMD_B1_I[1:0];
    wire                       fld_range = CMD_B1_I < 8'(`ECSU_NFIELD);
    wire                       fld_ok    = fld_range & fld_on[fld];
    wire ecsu_pkg::ecsu_size_t new_size  = CMD_B2_I[6:0];
    wire ecsu_pkg::ecsu_byte_t old_used  = fld_ok ? {1'b0, fld_size[fld]} : 8'h00;
    wire ecsu_pkg::ecsu_byte_t free      = `ECSU_MEM_BYTES - used;
    wire                       size_ok   = (new_size != 7'h00) && (new_size <= `ECSU_FLD_MAX)
                                           && ({1'b0, new_size} <= free + old_used);
    wire                       key_ok    = CMD_B1_I == acc_code[0];
    wire                       ch_ok     = (CMD_B1_I == `ECSU_CH_TEMP) || (CMD_B1_I == `ECSU_CH_ALT);
    wire [5:0]                 maddr     = {fld, CMD_B2_I[3:0]};
    wire                       speed     = flt[`ECSU_F_SPEED];
    wire ecsu_pkg::ecsu_fault_t rise     = flt & ~flt_q;
    wire ecsu_pkg::ecsu_byte_t rise_code = fault_code(rise);

    wire is_pset = CMD_CODE_I == `ECSU_CMD_POS_SET;
    wire is_clr  = CMD_CODE_I == `ECSU_CMD_CNT_CLR;
    wire is_rd   = CMD_CODE_I == `ECSU_CMD_DAT_RD;
    wire is_wr   = CMD_CODE_I == `ECSU_CMD_DAT_WR;
    wire is_fst  = CMD_CODE_I == `ECSU_CMD_FLD_ST;
    wire is_mk   = CMD_CODE_I == `ECSU_CMD_FLD_MK;
    wire uses_f  = is_rd | is_wr | is_fst;

    // Frame checks first, then unknown code and length, then per-command checks
    wire ecsu_pkg::ecsu_byte_t cmd_st =
        PARITY_ERR_I                                        ? `ECSU_ST_PARITY  :
        CSUM_ERR_I                                          ? `ECSU_ST_FCSUM   :
        !el[3]                                              ? `ECSU_ST_UNKNOWN :
        ({1'b0, CMD_LEN_I} != el[2:0] + 4'h0)               ? `ECSU_ST_LENGTH  :
        ((is_pset | is_clr) && !key_ok)                     ? `ECSU_ST_ACCESS  :
        (CMD_CODE_I == `ECSU_CMD_ANA_RD && !ch_ok)          ? `ECSU_ST_ARG     :
        (CMD_CODE_I == `ECSU_CMD_POS_RD && speed)           ? `ECSU_ST_SPEED   :
        (uses_f && !fld_ok)                                 ? `ECSU_ST_NOFIELD :
        ((is_rd | is_wr) && {1'b0, CMD_B2_I} >= {2'b00, fld_size[fld]})
                                                            ? `ECSU_ST_WADDR   :
        (is_wr && CMD_B4_I != acc_code[fld])                ? `ECSU_ST_ACCESS  :
        (is_wr && fld_wp[fld])                              ? `ECSU_ST_WPROT   :
        (is_mk && !fld_range)                               ? `ECSU_ST_ARG     :
        (is_mk && CMD_B3_I != acc_code[0])                  ? `ECSU_ST_ACCESS  :
        (is_mk && fld_ok && fld_fix[fld])                   ? `ECSU_ST_FIXED   :
        (is_mk && !size_ok)                                 ? `ECSU_ST_ARG     :
                                                              `ECSU_ST_OK;
    wire cmd_ok = take && cmd_st == `ECSU_ST_OK;

    // Answer data per command
    wire [15:0] cmd_data =
        (CMD_CODE_I == `ECSU_CMD_POS_RD)  ? {1'b0, POSITION_I + pos_ofs} :
        (CMD_CODE_I == `ECSU_CMD_ANA_RD)  ? {8'h00, TEMP_I}              :
        (CMD_CODE_I == `ECSU_CMD_CNT_RD)  ? counter                      :
        is_rd                             ? {8'h00, mem[maddr]}          :
        is_fst ? {fld_wp[fld], fld_fix[fld], 7'h00, fld_size[fld]}       :
        (CMD_CODE_I == `ECSU_CMD_FREE)    ? {8'h00, free}                :
        (CMD_CODE_I == `ECSU_CMD_STAT_RD) ? {8'h00, ERR_CODE_O}          :
                                            16'h0000;

    // Latest error kept; a status read while no fault line is active clears it
    wire ecsu_pkg::ecsu_byte_t next_err =
        (take && cmd_st != `ECSU_ST_OK)         ? cmd_st    :
        (rise != '0)                            ? rise_code :
        (cmd_ok && CMD_CODE_I == `ECSU_CMD_STAT_RD && flt == '0)
                                                ? `ECSU_ST_OK : ERR_CODE_O;

    always_ff @(posedge CLK_I or negedge rst_n)
    begin
        if (!rst_n)
        begin
            RSP_VALID_O  <= 1'b0;
            RSP_STATUS_O <= `ECSU_ST_OK;
            RSP_DATA_O   <= 16'h0000;
            ERR_CODE_O   <= `ECSU_ST_OK;
            ADDR_O       <= `ECSU_DEF_ADDR;
            LINE_MODE_O  <= `ECSU_DEF_MODE;
            flt_q        <= '0;
            pos_ofs      <= 15'h0000;
            counter      <= `ECSU_DEF_COUNT;
            used         <= 8'(`ECSU_FLD_MAX);
            for (int i = 0; i < `ECSU_NFIELD; i++)
            begin
                acc_code[i] <= `ECSU_DEF_CODE;
                fld_on[i]   <= (i == 0);
                fld_wp[i]   <= 1'b0;
                fld_fix[i]  <= (i == 0);
                fld_size[i] <= (i == 0) ? `ECSU_FLD_MAX : 7'h00;
            end
        end
        else if (CE_I)
        begin
            RSP_VALID_O  <= CMD_STROBE_I;
            RSP_STATUS_O <= CMD_STROBE_I ? cmd_st : RSP_STATUS_O;
            RSP_DATA_O   <= cmd_ok ? cmd_data : 16'h0000;
            ERR_CODE_O   <= next_err;
            flt_q        <= flt;
            if (cmd_ok && is_pset)
            begin
                pos_ofs <= {CMD_B2_I[6:0], CMD_B3_I} - POSITION_I;
            end
            if (cmd_ok && CMD_CODE_I == `ECSU_CMD_CNT_INC)
            begin
                counter <= counter + 16'h0001;
            end
            if (cmd_ok && is_clr)
            begin
                counter <= `ECSU_DEF_COUNT;
            end
            if (cmd_ok && is_mk)
            begin
                fld_on[fld]   <= 1'b1;
                fld_wp[fld]   <= CMD_B2_I[7];
                fld_size[fld] <= new_size;
                used          <= used - old_used + {1'b0, new_size};
            end
        end
    end

    // Field storage carries no reset
    always_ff @(posedge CLK_I)
    begin
        if (cmd_ok && is_wr)
        begin
            mem[maddr] <= CMD_B3_I;
        end
    end

    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!rst_n);

    a_parity_code: assert property (take && PARITY_ERR_I |=> RSP_VALID_O && RSP_STATUS_O == 8'h09)
        else $error("parity error not reported");
    a_unknown_cmd: assert property (take && !PARITY_ERR_I && !CSUM_ERR_I && el == 4'h0
        |=> RSP_STATUS_O == 8'h0B && ERR_CODE_O == 8'h0B)
        else $error("unknown command not reported");
    a_key_check: assert property (take && is_pset && !PARITY_ERR_I && !CSUM_ERR_I
        && CMD_LEN_I == 3'd3 && !key_ok |=> RSP_STATUS_O == 8'h0F && $stable(pos_ofs))
        else $error("position set without key accepted");
    a_speed_block: assert property (take && CMD_CODE_I == 8'h42 && speed && !PARITY_ERR_I
        && !CSUM_ERR_I && CMD_LEN_I == 3'd0 |=> RSP_STATUS_O == 8'h1F)
        else $error("position given at overspeed");
    a_wprot_hold: assert property (take && is_wr && fld_wp[fld] |=> RSP_STATUS_O != 8'h00)
        else $error("write to protected field accepted");
    a_cnt_inc: assert property (cmd_ok && CMD_CODE_I == 8'h47 |=> counter == $past(counter) + 16'h0001)
        else $error("counter did not increment");
    a_nofield: assert property (take && is_fst && !fld_ok && el[3] && !PARITY_ERR_I
        && !CSUM_ERR_I && CMD_LEN_I == 3'd1 |=> RSP_STATUS_O == 8'h12)
        else $error("missing field not reported");
    a_wdog_code: assert property (CE_I && !take && rise == 11'h040 |=> ERR_CODE_O == 8'h07)
        else $error("watchdog restart not reported");
    a_status_read: assert property (cmd_ok && CMD_CODE_I == 8'h50 |=> RSP_DATA_O[7:0] == $past(ERR_CODE_O))
        else $error("status read lost error code");
    a_free_mem: assert property (cmd_ok && CMD_CODE_I == 8'h4E |=> RSP_DATA_O[7:0] == 8'h40 - $past(used))
        else $error("free memory wrong");

    c_pos_read: cover property (cmd_ok && CMD_CODE_I == 8'h42);
    c_create:   cover property (cmd_ok && is_mk);
    c_store:    cover property (cmd_ok && is_wr);
    c_fault:    cover property (rise != '0);
endmodule

// file: tb/ecsu_ctrl_model.sv
// Drive controller model presenting parsed command frames to the unit
`timescale 1ns/1ns
module ecsu_ctrl_model (
    input  wire logic                 clk_i,
    input  wire logic                 rsp_valid_i,
    input  wire ecsu_pkg::ecsu_byte_t rsp_status_i,
    input  wire logic [15:0]          rsp_data_i,
    output logic                      strobe_o,
    output ecsu_pkg::ecsu_byte_t      code_o,
    output logic [2:0]                len_o,
    output ecsu_pkg::ecsu_byte_t      b1_o,
    output ecsu_pkg::ecsu_byte_t      b2_o,
    output ecsu_pkg::ecsu_byte_t      b3_o,
    output ecsu_pkg::ecsu_byte_t      b4_o,
    output logic                      parity_err_o,
    output logic                      csum_err_o
);
    initial
    begin
        strobe_o = 1'b0;
        code_o = 8'h00;
        len_o = 3'h0;
        b1_o = 8'h00;
        b2_o = 8'h00;
        b3_o = 8'h00;
        b4_o = 8'h00;
        parity_err_o = 1'b0;
        csum_err_o = 1'b0;
    end

    // One frame, then wait a bounded time for the single-cycle answer
    task automatic send(input ecsu_pkg::ecsu_byte_t c, input logic [2:0] n,
                        input ecsu_pkg::ecsu_byte_t x1, x2, x3, x4, input logic [1:0] fe,
                        output ecsu_pkg::ecsu_byte_t st, output logic [15:0] d,
                        output logic ok);
        @(posedge clk_i);
        strobe_o <= 1'b1;
        code_o <= c;
        len_o <= n;
        b1_o <= x1; // Key byte rides in the frame as the caller gives it
        b2_o <= x2;
        b3_o <= x3; // Key byte of field creation
        b4_o <= x4;
        parity_err_o <= fe[1];
        csum_err_o <= fe[0];
        @(posedge clk_i);
        // Stale bytes are inverted so a late sample cannot pass by luck
        strobe_o <= 1'b0;
        code_o <= ~c;
        b1_o <= ~x1;
        b2_o <= ~x2;
        b3_o <= ~x3;
        b4_o <= ~x4;
        parity_err_o <= 1'b0;
        csum_err_o <= 1'b0;
        ok = 1'b0;
        // Answer pulse is launched by the taking edge, so look just after it first
        for (int k = 0; k < 4 && !ok; k++)
        begin
            #1;
            if (rsp_valid_i === 1'b1)
            begin
                ok = 1'b1;
                st = rsp_status_i;
                d = rsp_data_i;
            end
            else
            begin
                @(posedge clk_i);
            end
        end
    endtask
endmodule

// file: tb/encoder_command_status_unit_test.sv
// Self-checking bench of the encoder command and status unit
`timescale 1ns/1ns
module encoder_command_status_unit_test;
    logic                  clk;
    logic                  rst_n;
    logic                  ce;
    logic [14:0]           pos;
    ecsu_pkg::ecsu_byte_t  temp;
    ecsu_pkg::ecsu_fault_t fault;
    logic [1:0]            fe;
    logic                  stb, perr, cerr, rv;
    logic [2:0]            len;
    ecsu_pkg::ecsu_byte_t  code, b1, b2, b3, b4, rst_st, err, addr, mode;
    logic [15:0]           rdat;
    int                    failures;
    int                    checked;
    ecsu_pkg::ecsu_byte_t  frz_st;
    logic [15:0]           frz_data;
    logic                  frz_ok;
    // Fault bit order: alignment up to temperature
    ecsu_pkg::ecsu_byte_t  fcode [0:10] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06,
                                            8'h07, 8'h1F, 8'h1C, 8'h1D, 8'h1E};

    always #10 clk = ~clk;

    ecsu_ctrl_model ctl (.clk_i(clk), .rsp_valid_i(rv), .rsp_status_i(rst_st),
        .rsp_data_i(rdat), .strobe_o(stb), .code_o(code), .len_o(len), .b1_o(b1),
        .b2_o(b2), .b3_o(b3), .b4_o(b4), .parity_err_o(perr), .csum_err_o(cerr));

    ecsu_top dut (.CLK_I(clk), .RST_N_I(rst_n), .CE_I(ce), .CMD_STROBE_I(stb),
        .CMD_CODE_I(code), .CMD_LEN_I(len), .CMD_B1_I(b1), .CMD_B2_I(b2), .CMD_B3_I(b3),
        .CMD_B4_I(b4), .PARITY_ERR_I(perr), .CSUM_ERR_I(cerr), .POSITION_I(pos),
        .TEMP_I(temp), .FAULT_I(fault), .RSP_VALID_O(rv), .RSP_STATUS_O(rst_st),
        .RSP_DATA_O(rdat), .ERR_CODE_O(err), .ADDR_O(addr), .LINE_MODE_O(mode));

    task automatic end_of_test();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk8(input string what, input ecsu_pkg::ecsu_byte_t e, g);
        checked++;
        if (g !== e)
        begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", what, e, g);
        end
    endtask

    task automatic chk16(input string what, input logic [15:0] e, g);
        checked++;
        if (g !== e)
        begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", what, e, g);
        end
    endtask

    // Data is zero on every refused command, so it is always compared
    task automatic run(input ecsu_pkg::ecsu_byte_t c, input logic [2:0] n,
                       input ecsu_pkg::ecsu_byte_t est, input logic [15:0] edat,
                       input ecsu_pkg::ecsu_byte_t x1 = 8'h00, x2 = 8'h00,
                       x3 = 8'h00, x4 = 8'h00);
        ecsu_pkg::ecsu_byte_t st;
        logic [15:0]          d;
        logic                 ok;
        ctl.send(c, n, x1, x2, x3, x4, fe, st, d, ok);
        if (!ok)
        begin
            failures++;
            $display("unexpected answer: expected 1, seen 0");
            end_of_test();
        end
        else
        begin
            chk8("status", est, st);
            chk16("data", edat, d);
        end
    endtask

    task automatic err_after(input ecsu_pkg::ecsu_byte_t e);
        @(posedge clk);
        #1;
        chk8("error code", e, err);
    endtask

    initial
    begin
        clk = 1'b0;
        rst_n = 1'b0;
        ce = 1'b1;
        pos = 15'h1234;
        temp = 8'h2A;
        fault = '0;
        fe = 2'b00;
        failures = 0;
        checked = 0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
        chk8("address", 8'h40, addr);
        chk8("line mode", 8'hE4, mode);
        chk8("error code", 8'h00, err);
        run(8'h46, 3'd0, 8'h00, 16'h0000);
        run(8'h47, 3'd0, 8'h00, 16'h0000);
        run(8'h46, 3'd0, 8'h00, 16'h0001);
        run(8'h49, 3'd1, 8'h0F, 16'h0000, 8'h54);
        err_after(8'h0F);
        run(8'h50, 3'd0, 8'h00, 16'h000F);
        err_after(8'h00);
        run(8'h49, 3'd1, 8'h00, 16'h0000, 8'h55);
        run(8'h46, 3'd0, 8'h00, 16'h0000);
        run(8'h42, 3'd0, 8'h00, 16'h1234);
        run(8'h43, 3'd3, 8'h00, 16'h0000, 8'h55, 8'h05, 8'h67);
        run(8'h42, 3'd0, 8'h00, 16'h0567);
        run(8'h43, 3'd3, 8'h0F, 16'h0000, 8'h56, 8'h01, 8'h01);
        run(8'h44, 3'd1, 8'h00, 16'h002A, 8'h48);
        run(8'h44, 3'd1, 8'h00, 16'h002A, 8'hF0);
        run(8'h44, 3'd1, 8'h0D, 16'h0000, 8'h33);
        run(8'h4E, 3'd0, 8'h00, 16'h0030);
        run(8'h4C, 3'd1, 8'h00, 16'h4010, 8'h00);
        run(8'h4C, 3'd1, 8'h12, 16'h0000, 8'h01);
        run(8'h4D, 3'd3, 8'h00, 16'h0000, 8'h01, 8'h08, 8'h55);
        run(8'h4C, 3'd1, 8'h00, 16'h0008, 8'h01);
        run(8'h4E, 3'd0, 8'h00, 16'h0028);
        run(8'h4D, 3'd3, 8'h10, 16'h0000, 8'h00, 8'h08, 8'h55);
        run(8'h4D, 3'd3, 8'h0D, 16'h0000, 8'h04, 8'h08, 8'h55);
        run(8'h4D, 3'd3, 8'h0F, 16'h0000, 8'h02, 8'h08, 8'h54);
        run(8'h4D, 3'd3, 8'h0D, 16'h0000, 8'h02, 8'h00, 8'h55);
        run(8'h4D, 3'd3, 8'h0D, 16'h0000, 8'h02, 8'h11, 8'h55);
        run(8'h4B, 3'd4, 8'h00, 16'h0000, 8'h00, 8'h03, 8'hA5, 8'h55);
        run(8'h4A, 3'd2, 8'h00, 16'h00A5, 8'h00, 8'h03);
        run(8'h4A, 3'd2, 8'h11, 16'h0000, 8'h00, 8'h10);
        run(8'h4B, 3'd4, 8'h0F, 16'h0000, 8'h00, 8'h00, 8'h11, 8'h54);
        run(8'h4A, 3'd2, 8'h12, 16'h0000, 8'h02, 8'h00);
        run(8'h4D, 3'd3, 8'h00, 16'h0000, 8'h01, 8'h84, 8'h55);
        run(8'h4B, 3'd4, 8'h0E, 16'h0000, 8'h01, 8'h00, 8'h11, 8'h55);
        run(8'h4A, 3'd2, 8'h11, 16'h0000, 8'h01, 8'h04);
        run(8'h46, 3'd1, 8'h0C, 16'h0000);
        run(8'h41, 3'd0, 8'h0B, 16'h0000);
        fe = 2'b10;
        run(8'h46, 3'd0, 8'h09, 16'h0000);
        fe = 2'b01;
        run(8'h46, 3'd0, 8'h0A, 16'h0000);
        fe = 2'b11;
        run(8'h46, 3'd0, 8'h09, 16'h0000);
        fe = 2'b00;
        err_after(8'h09);
        // Clock enable low: frame ignored, counter untouched
        @(posedge clk);
        ce <= 1'b0;
        ctl.send(8'h47, 3'd0, 8'h00, 8'h00, 8'h00, 8'h00, 2'b00, frz_st, frz_data, frz_ok);
        chk8("answer while frozen", 8'h00, {7'h00, frz_ok});
        @(posedge clk);
        ce <= 1'b1;
        run(8'h46, 3'd0, 8'h00, 16'h0000);
        err_after(8'h09);
        for (int i = 0; i < 11; i++)
        begin
            @(posedge clk);
            fault[i] <= 1'b1;
            repeat (8) @(posedge clk);
            #1;
            chk8("fault code", fcode[i], err);
            if (i == 7)
                run(8'h42, 3'd0, 8'h1F, 16'h0000);
            @(posedge clk);
            fault[i] <= 1'b0;
            repeat (8) @(posedge clk);
            run(8'h50, 3'd0, 8'h00, {8'h00, fcode[i]});
            err_after(8'h00);
        end
        end_of_test();
    end
endmodule
